// ---- dtc_pkg.sv ----
/*
  Shared constants and types for the DMA channel transfer engine:
  register map, control word fields, states and the bus request carrier.
  Assumes a single clock domain and a 32-bit APB register port.
*/
package dtc_pkg;

  // Register byte offsets (one aligned word each)
  localparam logic [7:0] DTC_OFF_PTR_A = 8'h00;
  localparam logic [7:0] DTC_OFF_PTR_B = 8'h04;
  localparam logic [7:0] DTC_OFF_PTR_C = 8'h08;
  localparam logic [7:0] DTC_OFF_CCW = 8'h0C;
  localparam logic [7:0] DTC_OFF_BC = 8'h10;
  localparam logic [7:0] DTC_OFF_MC = 8'h14;
  localparam logic [7:0] DTC_OFF_TP = 8'h18;
  localparam logic [7:0] DTC_OFF_WID = 8'h1C;
  localparam logic [7:0] DTC_OFF_CMD = 8'h20;
  localparam logic [7:0] DTC_OFF_STAT = 8'h24;

  // Channel control word field positions
  localparam int DTC_CCW_SRC_MEM = 15;
  localparam int DTC_CCW_DST_MEM = 14;
  localparam int DTC_CCW_XLATE = 13;
  localparam int DTC_CCW_SYNC_HI = 12;
  localparam int DTC_CCW_SYNC_LO = 11;
  localparam int DTC_CCW_SRC_B = 10;
  localparam int DTC_CCW_SINGLE = 7;
  localparam int DTC_CCW_EXT_HI = 6;
  localparam int DTC_CCW_BC_HI = 4;
  localparam int DTC_CCW_CMP_NE = 2;
  localparam int DTC_CCW_CMP_HI = 1;

  // Synchronization field encodings
  localparam logic [1:0] DTC_SYNC_NONE = 2'h0;
  localparam logic [1:0] DTC_SYNC_SRC = 2'h1;
  localparam logic [1:0] DTC_SYNC_DST = 2'h2;

  // Termination offset codes: 00 disabled, 01/10/11 give 0/4/8 bytes
  localparam logic [1:0] DTC_TERM_OFF = 2'h0;
  localparam logic [3:0] DTC_STEP_OFFSET = 4'h4;

  // Command register bits and width register bits
  localparam int DTC_CMD_ENTER_TRANSFER_INSTR = 0;
  localparam int DTC_CMD_STEP = 1;
  localparam int DTC_CMD_HALT = 2;
  localparam int DTC_WID_SRC16 = 0;
  localparam int DTC_WID_DST16 = 1;

  // Reset values
  localparam logic [15:0] DTC_CCW_RST = 16'h0000;
  localparam logic [15:0] DTC_BC_RST = 16'h0000;

  // Sequencer states
  typedef enum logic [3:0] {
    DTC_IDLE, DTC_ARMED, DTC_WAIT_SRC, DTC_FETCH, DTC_XLATE,
    DTC_STORE_GO, DTC_WAIT_DST, DTC_STORE, DTC_UPDATE
  } dtc_state_t;

  // Request towards the memory / I/O bus
  typedef struct packed {
    logic req;
    logic we;
    logic io;
    logic word;
    logic [19:0] addr;
    logic [15:0] wdata;
  } dtc_bus_req_t;

endpackage

// ---- dtc_channel.sv ----
/*
  One DMA channel transfer engine with an APB register port and a
  request/acknowledge master port towards memory and I/O peripherals.
  Assumes one clock (mclk), the bus master answering each request with a
  one-cycle mem_ack, and byte data carried in mem_rdata[7:0].
*/
// Notes on behaviour
// - Transfer starts after one further instruction.
// - Halt after transfer clears busy, DMA continues.
// - Cycles repeat until a termination condition.
// - Source sync waits request before fetching.
// - Byte source to even word destination assembles.
// - Fetch/store size follows parity and widths.
// - Byte counter drops by bytes fetched.
// - Terminate sampled each cycle; skips second fetch.
// - Translate fetched data when enabled.
// - Word split into bytes for byte stores.
// - Destination sync waits request before store.
// - Word stores to 16-bit memory where possible.
// - Terminate after first store drops second.
// - Compare hit drops second store.
// - Only memory pointers increment.
// - On termination add offset to task pointer.
// - Remaining byte stored, then recheck termination.
// - Counter and memory pointers left modified.
// - Simultaneous terminations report largest offset.
// - Masked compare uses high byte as mask.
// - Single transfer: one cycle, offset zero.
// - Two-bit field selects synchronization type.
`timescale 1ns/1ps
module dtc_channel
  import dtc_pkg::*;
#(
  parameter int ADDR_W = 20
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic transfer_request,
  input wire logic external_terminate,
  output dtc_bus_req_t bus_out,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  output logic busy,
  output logic dma_active
);

  // Bus carrier holds a 20-bit address; wider or tiny pointers are refused
  if (ADDR_W != 20) begin : g_bad_addr_w
    $error("dtc_channel: ADDR_W must be 20");
  end

  // Offset in bytes for a termination code, zero when disabled
  function automatic logic [3:0] off_of(input logic [1:0] code);
    case (code)
      2'h1: off_of = 4'h0;
      2'h2: off_of = 4'h4;
      2'h3: off_of = 4'h8;
      default: off_of = 4'h0;
    endcase
  endfunction

  // Masked compare; high byte bits set mean "ignore this bit"
  function automatic logic cmp_hit(input logic [7:0] b, input logic [15:0] mc,
                                   input logic ne);
    logic eq;
    eq = ((b ^ mc[7:0]) & ~mc[15:8]) == 8'h00;
    cmp_hit = ne ? !eq : eq;
  endfunction

  // Software visible registers
  logic [ADDR_W-1:0] pointer_a; // Pointer A
  logic [ADDR_W-1:0] pointer_b; // Pointer B
  logic [ADDR_W-1:0] pointer_c; // Translate table base
  logic [15:0] channel_control_word;
  logic [15:0] byte_counter;
  logic [15:0] mask_compare_word;
  logic [ADDR_W-1:0] task_pointer;
  logic [1:0] bus_width; // Logical widths, 1 = 16 bit
  logic [3:0] last_offset; // Offset added at the last termination

  // Sequencer state
  dtc_state_t state;
  logic issued; // Bus request outstanding
  logic fetch_idx; // Second of two fetches
  logic store_idx; // Second of two stores
  logic xl_idx; // Byte being translated
  logic [1:0] nbytes; // Bytes held this cycle
  logic [15:0] data; // Assembly / disassembly holding register
  logic ext_hit; // Terminate seen in this cycle
  logic cmp_flag; // Compare hit in this cycle

  // Pin synchronisers: first stage feeds only the second
  logic ext_m, ext_s, drq_m, drq_s;

  // Decoded control word
  logic [1:0] sync_sel;
  logic src_is_b, src_mem, dst_mem;
  logic [ADDR_W-1:0] src_ptr, dst_ptr;
  logic src16, dst16, fetch_word, two_fetch, store_word, more_bytes;
  logic ext_now, single;
  logic [3:0] term_off;
  logic term_any, bc_term;

  // APB decode
  logic apb_wr, apb_setup, in_dma, dma_active_c;

  assign sync_sel = channel_control_word[DTC_CCW_SYNC_HI:DTC_CCW_SYNC_LO];
  assign src_is_b = channel_control_word[DTC_CCW_SRC_B];
  assign src_mem = channel_control_word[DTC_CCW_SRC_MEM];
  assign dst_mem = channel_control_word[DTC_CCW_DST_MEM];
  assign single = channel_control_word[DTC_CCW_SINGLE];
  assign src_ptr = src_is_b ? pointer_b : pointer_a;
  assign dst_ptr = src_is_b ? pointer_a : pointer_b;
  assign src16 = bus_width[DTC_WID_SRC16];
  assign dst16 = bus_width[DTC_WID_DST16];
  // Sizing from address parity and logical widths
  assign fetch_word = src16 && !src_ptr[0];
  assign two_fetch = !fetch_word && dst16 && !dst_ptr[0];
  assign store_word = dst16 && !dst_ptr[0] && (nbytes == 2'd2) && (store_idx == 1'b0);
  assign more_bytes = (nbytes == 2'd2) && !store_word && (store_idx == 1'b0);
  // Terminate only counts while the request line is idle
  assign ext_now = ext_s && !drq_s;
  assign bc_term = (channel_control_word[DTC_CCW_BC_HI -: 2] != DTC_TERM_OFF)
                   && (byte_counter == 16'h0000);
  assign apb_wr = psel && penable && pready && pwrite;
  assign apb_setup = psel && !penable && !pready;
  assign in_dma = (state != DTC_IDLE) && (state != DTC_ARMED);
  assign dma_active_c = in_dma;

  // Largest offset among the conditions that fired this cycle
  always_comb begin
    logic [3:0] o_ext, o_bc, o_cmp;
    o_ext = 4'h0;
    o_bc = 4'h0;
    o_cmp = 4'h0;
    if (ext_hit && channel_control_word[DTC_CCW_EXT_HI -: 2] != DTC_TERM_OFF) begin
      o_ext = off_of(channel_control_word[DTC_CCW_EXT_HI -: 2]);
    end
    if (bc_term && !more_bytes) begin
      o_bc = off_of(channel_control_word[DTC_CCW_BC_HI -: 2]);
    end
    if (cmp_flag) begin
      o_cmp = off_of(channel_control_word[DTC_CCW_CMP_HI -: 2]);
    end
    term_off = o_ext;
    if (o_bc > term_off) begin
      term_off = o_bc;
    end
    if (o_cmp > term_off) begin
      term_off = o_cmp;
    end
    term_any = (ext_hit && channel_control_word[DTC_CCW_EXT_HI -: 2] != DTC_TERM_OFF)
               || (bc_term && !more_bytes) || cmp_flag;
  end

  // Two-flop synchronisers for the peripheral pins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ext_m <= 1'b0;
      ext_s <= 1'b0;
      drq_m <= 1'b0;
      drq_s <= 1'b0;
    end else begin
      ext_m <= external_terminate;
      ext_s <= ext_m;
      drq_m <= transfer_request;
      drq_s <= drq_m;
    end
  end

  // APB answer: ready one cycle after setup, data and error registered
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        pslverr <= (paddr[1:0] != 2'h0) || (paddr > DTC_OFF_STAT);
        case (paddr)
          DTC_OFF_PTR_A: prdata <= 32'(pointer_a);
          DTC_OFF_PTR_B: prdata <= 32'(pointer_b);
          DTC_OFF_PTR_C: prdata <= 32'(pointer_c);
          DTC_OFF_CCW: prdata <= {16'h0000, channel_control_word};
          DTC_OFF_BC: prdata <= {16'h0000, byte_counter};
          DTC_OFF_MC: prdata <= {16'h0000, mask_compare_word};
          DTC_OFF_TP: prdata <= 32'(task_pointer);
          DTC_OFF_WID: prdata <= {30'h0000_0000, bus_width};
          DTC_OFF_STAT: prdata <= {24'h00_0000, last_offset, 2'h0, dma_active, busy};
          default: prdata <= 32'h0000_0000;
        endcase
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Configuration registers; software writes are ignored during DMA
  // so the engine alone owns them while it runs
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pointer_c <= '0;
      channel_control_word <= DTC_CCW_RST;
      mask_compare_word <= 16'h0000;
      bus_width <= 2'h0;
    end else if (apb_wr && !in_dma) begin
      case (paddr)
        DTC_OFF_PTR_C: pointer_c <= pwdata[ADDR_W-1:0];
        DTC_OFF_CCW: channel_control_word <= pwdata[15:0];
        DTC_OFF_MC: mask_compare_word <= pwdata[15:0];
        DTC_OFF_WID: bus_width <= pwdata[1:0];
        default: ;
      endcase
    end
  end

  // Busy flag: set by the transfer command, cleared by a halt
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else if (apb_wr && paddr == DTC_OFF_CMD) begin
      if (pwdata[DTC_CMD_ENTER_TRANSFER_INSTR]) begin
        busy <= 1'b1;
      end else if (pwdata[DTC_CMD_HALT]) begin
        busy <= 1'b0;
      end
    end
  end

  // Registered copy of the running flag for the pin
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dma_active <= 1'b0;
    end else begin
      dma_active <= dma_active_c;
    end
  end

  // Main sequencer: pointers, counter, data path and bus requests
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state <= DTC_IDLE;
      pointer_a <= '0;
      pointer_b <= '0;
      byte_counter <= DTC_BC_RST;
      task_pointer <= '0;
      last_offset <= 4'h0;
      issued <= 1'b0;
      fetch_idx <= 1'b0;
      store_idx <= 1'b0;
      xl_idx <= 1'b0;
      nbytes <= 2'd0;
      data <= 16'h0000;
      ext_hit <= 1'b0;
      cmp_flag <= 1'b0;
      bus_out <= '0;
    end else begin
      case (state)
        // Idle: software owns pointers, counter and task pointer
        DTC_IDLE: begin
          if (apb_wr) begin
            case (paddr)
              DTC_OFF_PTR_A: pointer_a <= pwdata[ADDR_W-1:0];
              DTC_OFF_PTR_B: pointer_b <= pwdata[ADDR_W-1:0];
              DTC_OFF_BC: byte_counter <= pwdata[15:0];
              DTC_OFF_TP: task_pointer <= pwdata[ADDR_W-1:0];
              DTC_OFF_CMD: begin
                if (pwdata[DTC_CMD_ENTER_TRANSFER_INSTR]) begin
                  state <= DTC_ARMED;
                end
              end
              default: ;
            endcase
          end
        end
        // Armed: one more instruction runs, then DMA begins
        DTC_ARMED: begin
          // A halt in this slot still counts as the following instruction
          if (apb_wr && paddr == DTC_OFF_CMD && (pwdata[DTC_CMD_STEP] || pwdata[DTC_CMD_HALT])) begin
            // Resume point is after the following instruction
            task_pointer <= task_pointer + ADDR_W'(DTC_STEP_OFFSET);
            ext_hit <= 1'b0;
            cmp_flag <= 1'b0;
            fetch_idx <= 1'b0;
            store_idx <= 1'b0;
            state <= (sync_sel == DTC_SYNC_SRC) ? DTC_WAIT_SRC : DTC_FETCH;
          end
        end
        // Source-synchronized: wait for the request line
        DTC_WAIT_SRC: begin
          if (drq_s) begin
            state <= DTC_FETCH;
          end
        end
        // Fetch one byte or word; a second byte when assembling
        DTC_FETCH: begin
          if (!issued) begin
            issued <= 1'b1;
            bus_out.req <= 1'b1;
            bus_out.we <= 1'b0;
            bus_out.io <= !src_mem;
            bus_out.word <= fetch_word;
            bus_out.addr <= src_mem ? src_ptr + ADDR_W'(fetch_idx) : src_ptr;
          end else begin
            bus_out.req <= 1'b0;
            if (mem_ack) begin
              issued <= 1'b0;
              if (fetch_word) begin
                data <= mem_rdata;
                byte_counter <= byte_counter - 16'h0002;
              end else begin
                if (fetch_idx) begin
                  data[15:8] <= mem_rdata[7:0];
                end else begin
                  data[7:0] <= mem_rdata[7:0];
                end
                byte_counter <= byte_counter - 16'h0001;
              end
              ext_hit <= ext_hit || ext_now;
              if (two_fetch && !fetch_idx && !ext_now) begin
                fetch_idx <= 1'b1;
              end else begin
                nbytes <= (fetch_word || fetch_idx) ? 2'd2 : 2'd1;
                xl_idx <= 1'b0;
                state <= channel_control_word[DTC_CCW_XLATE] ? DTC_XLATE
                                                             : DTC_STORE_GO;
              end
            end
          end
        end
        // Translate each held byte through the lookup table
        DTC_XLATE: begin
          if (!issued) begin
            issued <= 1'b1;
            bus_out.req <= 1'b1;
            bus_out.we <= 1'b0;
            bus_out.io <= 1'b0;
            bus_out.word <= 1'b0;
            bus_out.addr <= pointer_c + ADDR_W'(xl_idx ? data[15:8] : data[7:0]);
          end else begin
            bus_out.req <= 1'b0;
            if (mem_ack) begin
              issued <= 1'b0;
              ext_hit <= ext_hit || ext_now;
              if (xl_idx) begin
                data[15:8] <= mem_rdata[7:0];
              end else begin
                data[7:0] <= mem_rdata[7:0];
              end
              if (!xl_idx && nbytes == 2'd2) begin
                xl_idx <= 1'b1;
              end else begin
                state <= DTC_STORE_GO;
              end
            end
          end
        end
        // Store entry: destination-synchronized waits for a request
        DTC_STORE_GO: begin
          state <= (sync_sel == DTC_SYNC_DST) ? DTC_WAIT_DST : DTC_STORE;
        end
        DTC_WAIT_DST: begin
          if (drq_s) begin
            state <= DTC_STORE;
          end
        end
        // Store the word or the lower-addressed byte first
        DTC_STORE: begin
          if (!issued) begin
            issued <= 1'b1;
            bus_out.req <= 1'b1;
            bus_out.we <= 1'b1;
            bus_out.io <= !dst_mem;
            bus_out.word <= store_word;
            bus_out.addr <= dst_ptr;
            // A lone byte rides on both lanes so either parity finds it
            bus_out.wdata <= store_word ? data
                           : (store_idx ? {2{data[15:8]}} : {2{data[7:0]}});
          end else begin
            bus_out.req <= 1'b0;
            if (mem_ack) begin
              issued <= 1'b0;
              ext_hit <= ext_hit || ext_now;
              if (channel_control_word[DTC_CCW_CMP_HI -: 2] != DTC_TERM_OFF &&
                  cmp_hit(store_idx ? data[15:8] : data[7:0], mask_compare_word,
                          channel_control_word[DTC_CCW_CMP_NE])) begin
                cmp_flag <= 1'b1;
              end
              state <= DTC_UPDATE;
            end
          end
        end
        // Update memory pointers, then decide: stop, second byte or next cycle
        DTC_UPDATE: begin
          if (src_mem && !store_idx) begin
            if (src_is_b) begin
              pointer_b <= pointer_b + ADDR_W'(nbytes);
            end else begin
              pointer_a <= pointer_a + ADDR_W'(nbytes);
            end
          end
          if (dst_mem) begin
            if (src_is_b) begin
              pointer_a <= pointer_a + (store_word ? ADDR_W'(2) : ADDR_W'(1));
            end else begin
              pointer_b <= pointer_b + (store_word ? ADDR_W'(2) : ADDR_W'(1));
            end
          end
          if (single && !more_bytes) begin
            // One whole cycle then resume at offset zero
            last_offset <= 4'h0;
            state <= DTC_IDLE;
          end else if (!single && term_any) begin
            // Stop and resume at the offset; the pending byte is dropped
            task_pointer <= task_pointer + ADDR_W'(term_off);
            last_offset <= term_off;
            state <= DTC_IDLE;
          end else if (more_bytes) begin
            store_idx <= 1'b1;
            state <= DTC_STORE_GO;
          end else begin
            // No stop yet: start the next cycle
            ext_hit <= 1'b0;
            cmp_flag <= 1'b0;
            fetch_idx <= 1'b0;
            store_idx <= 1'b0;
            state <= (sync_sel == DTC_SYNC_SRC) ? DTC_WAIT_SRC : DTC_FETCH;
          end
        end
        default: state <= DTC_IDLE;
      endcase
    end
  end

endmodule // dtc_channel

// ---- dtc_channel_chk.sv ----
/*
  Port checker for the DMA channel transfer engine.
  Assumes one clock, mclk, and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module dtc_channel_chk
  import dtc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic transfer_request,
  input wire logic external_terminate,
  input dtc_bus_req_t bus_out,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic busy,
  input wire logic dma_active
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [15:0] ccw; // Shadow of the control word
  logic [3:0] rq_age; // Cycles since the request pin was high, saturating
  // Track control word writes taken at the access edge
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ccw <= 16'h0000;
    end else if (psel && penable && pready && pwrite && paddr == DTC_OFF_CCW) begin
      ccw <= pwdata[15:0];
    end
  end
  // Age of the request; saturates so it never wraps back to a small value
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rq_age <= 4'hF;
    end else begin
      rq_age <= transfer_request ? 4'h0 : (rq_age == 4'hF ? rq_age : rq_age + 4'h1);
    end
  end
  property p_apb_ready; psel && !penable |=> pready && penable; endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("pready late");
  property p_ready_one; pready |=> !pready; endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_req_pulse; bus_out.req |=> !bus_out.req [*2]; endproperty
  a_req_pulse: assert property (p_req_pulse) else $error("req not a pulse");
  property p_ack_gap; mem_ack |-> !bus_out.req; endproperty
  a_ack_gap: assert property (p_ack_gap) else $error("req with ack");
  property p_word_even; bus_out.req && bus_out.word |-> !bus_out.addr[0]; endproperty
  a_word_even: assert property (p_word_even) else $error("odd word access");
  property p_lanes; bus_out.req && bus_out.we && !bus_out.word
    |-> bus_out.wdata[15:8] == bus_out.wdata[7:0]; endproperty
  a_lanes: assert property (p_lanes) else $error("byte lanes differ");
  property p_src_sync; ccw[12:11] == DTC_SYNC_SRC && bus_out.req && !bus_out.we
    |-> rq_age < 4'h8; endproperty
  a_src_sync: assert property (p_src_sync) else $error("fetch without request");
  property p_dst_sync; ccw[12:11] == DTC_SYNC_DST && bus_out.req && bus_out.we
    |-> rq_age < 4'h8; endproperty
  a_dst_sync: assert property (p_dst_sync) else $error("store without request");
  property p_req_active; bus_out.req |-> dma_active; endproperty
  a_req_active: assert property (p_req_active) else $error("bus cycle outside transfer");
  c_store: cover property (bus_out.req && bus_out.we);
  c_word: cover property (bus_out.req && bus_out.word);
  c_err: cover property (pslverr);
endmodule // dtc_channel_chk

// ---- dtc_mem.sv ----
/*
  Behavioural memory and port space on the far side of the channel.
  Assumes one request pulse per bus cycle; answers fast or slow.
*/
`timescale 1ns/1ps
module dtc_mem
  import dtc_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input dtc_bus_req_t bus_in,
  input wire logic slow,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [7:0] mem [0:1023]; // Byte array, loaded by the bench
  dtc_bus_req_t r; // Request held until answered
  logic pend;
  logic [1:0] cnt; // Extra wait cycles in slow mode
  logic [9:0] a;
  assign a = r.addr[9:0];
  // Answer each request; read data lines toggle when not valid
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend <= 1'b0;
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 16'h5A5A;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (bus_in.req) begin
        pend <= 1'b1;
        r <= bus_in;
        cnt <= slow ? 2'h3 : 2'h0;
      end else if (pend && cnt != 2'h0) begin
        cnt <= cnt - 2'h1;
      end else if (pend) begin
        pend <= 1'b0;
        mem_ack <= 1'b1;
        if (r.we) begin
          mem[a] <= r.wdata[7:0];
          if (r.word) mem[a + 10'h001] <= r.wdata[15:8];
        end else begin
          mem_rdata <= r.word ? {mem[a + 10'h001], mem[a]} : {~mem[a], mem[a]};
        end
      end
    end
  end
endmodule // dtc_mem

// ---- dtc_channel_transfer_cycle_tb_top.sv ----
/*
  Self-checking bench for the DMA channel: APB master, byte model, memory.
  Assumes a 100 MHz clock and the memory model answering every request.
*/
`timescale 1ns/1ps
module dtc_channel_transfer_cycle_tb_top
  import dtc_pkg::*;
;
  logic mclk, resetn, psel, penable, pwrite, pready, pslverr, busy, dma_active;
  logic transfer_request, external_terminate, mem_ack, slow, en_rq, en_ext, rr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] mem_rdata;
  dtc_bus_req_t bus_out;
  logic [7:0] sb [0:7]; // Source bytes
  logic [7:0] ex [0:7]; // Expected stored bytes
  int num_errors, n_checks, wc;
  dtc_channel dut_u (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .transfer_request, .external_terminate, .bus_out, .mem_ack,
    .mem_rdata, .busy, .dma_active);
  dtc_mem mem_u (.mclk, .resetn, .bus_in(bus_out), .slow, .mem_ack, .mem_rdata);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Peripheral: random request; terminate only while request is low
  always @(posedge mclk) begin
    rr = ($urandom % 3) == 0;
    transfer_request <= en_rq & rr;
    external_terminate <= en_ext & !rr & (($urandom % 8) == 0);
  end
  // Count word stores on the bus
  always @(posedge mclk) if (bus_out.req && bus_out.we && bus_out.word) wc++;
  task final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge mclk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin num_errors++; final_report(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Set up one transfer, model it, start it and compare the results
  task run(input logic [15:0] c, input logic [1:0] w, input logic [31:0] nc);
    int i, cnt, off, k;
    logic [7:0] x;
    logic [15:0] mk;
    bit stop;
    for (i = 0; i < 8; i++) begin
      sb[i] = $urandom;
      mem_u.mem[i] = sb[i];
      mem_u.mem[10'h040 + i] = 8'h00;
    end
    mk = {8'h0F, sb[7]}; // Low nibble ignored by the mask
    cnt = 0; off = c[6] ? 4 : 0; stop = 0;
    for (i = 0; i < 8 && !stop; i++) begin
      x = c[13] ? mem_u.mem[10'h100 + sb[i]] : sb[i];
      ex[i] = x;
      cnt++;
      if (c[7] || cnt == 8) stop = 1;
      if (!c[7] && c[1] && ((x ^ mk[7:0]) & ~mk[15:8]) == 8'h00) begin stop = 1; off = 4; end
    end
    slow <= $urandom % 2; en_rq <= c[12] | c[11]; en_ext <= c[6]; wc = 0;
    apb(1, DTC_OFF_PTR_A, 0); apb(1, DTC_OFF_PTR_B, 32'h0000_0040);
    apb(1, DTC_OFF_PTR_C, 32'h0000_0100); apb(1, DTC_OFF_CCW, {16'h0000, c});
    apb(1, DTC_OFF_BC, 8); apb(1, DTC_OFF_MC, {16'h0000, mk});
    apb(1, DTC_OFF_TP, 32'h0000_0100); apb(1, DTC_OFF_WID, {30'h0, w});
    apb(1, DTC_OFF_CMD, 1);
    repeat (5) @(posedge mclk);
    chk("early", dma_active, 0);
    apb(1, DTC_OFF_CMD, nc); // Leaves pointers and control word alone
    k = 0;
    while (dma_active !== 1'b1 && k < 20) begin @(posedge mclk); k++; end
    while (dma_active !== 1'b0 && k < 5000) begin @(posedge mclk); k++; end
    if (k >= 5000) begin num_errors++; final_report(); end
    en_rq <= 1'b0; en_ext <= 1'b0;
    if (!c[6]) begin
      for (i = 0; i < cnt; i++) if (c[14]) chk("dst", mem_u.mem[10'h040 + i], ex[i]);
      if (!c[14]) chk("port", mem_u.mem[10'h040], ex[cnt - 1]);
      apb(0, DTC_OFF_PTR_A, 0); chk("ptr_a", rd, cnt);
      apb(0, DTC_OFF_PTR_B, 0); chk("ptr_b", rd, c[14] ? 64 + cnt : 64);
      apb(0, DTC_OFF_BC, 0); chk("bc", rd, 8 - cnt);
      chk("words", wc, w[1] ? cnt / 2 : 0);
    end
    if (nc == 2) begin
      apb(0, DTC_OFF_TP, 0); chk("tp", rd, 32'h0000_0104 + off);
      apb(0, DTC_OFF_STAT, 0); chk("off", rd[7:4], off);
    end else begin
      chk("busy", busy, 0);
    end
  endtask
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; transfer_request = 1'b0; external_terminate = 1'b0;
    slow = 1'b0; en_rq = 1'b0; en_ext = 1'b0; num_errors = 0; n_checks = 0;
    void'($urandom(78415));
    for (int i = 0; i < 256; i++) mem_u.mem[10'h100 + i] = $urandom;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    apb(0, DTC_OFF_CCW, 0); chk("ccw_rst", rd, {16'h0000, DTC_CCW_RST});
    apb(0, DTC_OFF_BC, 0); chk("bc_rst", rd, {16'h0000, DTC_BC_RST});
    apb(0, 8'h28, 0); chk("unmapped", {rd[30:0], er}, 1);
    run(16'hC008, 2'h0, 2);
    run(16'hE008, 2'h0, 2);
    run(16'hC00A, 2'h0, 2);
    run(16'hC088, 2'h0, 2);
    run(16'h8008, 2'h0, 2);
    run(16'hC008, 2'h2, 2);
    run(16'hC008, 2'h3, 2);
    run(16'hC008, 2'h1, 2);
    run(16'hC808, 2'h0, 2);
    run(16'hD008, 2'h0, 2);
    run(16'hC840, 2'h0, 2);
    run(16'hC008, 2'h0, 4);
    final_report();
  end
endmodule // dtc_channel_transfer_cycle_tb_top
bind dtc_channel dtc_channel_chk chk_u (.mclk, .resetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .transfer_request, .external_terminate, .bus_out,
  .mem_ack, .mem_rdata, .busy, .dma_active);
